/* File: dv/plm_mgmt_model.sv */
// Management controller model driving the register port.
// Assumes the bench calls its tasks; requests change on rising edges.
`default_nettype none
module plm_mgmt_model
(
  // Clock and answers
  input wire logic clk,
  input wire logic mgmt_rd_ack,
  input wire plm_pkg::plm_word_t mgmt_rdata,
  // Requests
  output var plm_pkg::plm_index_t mgmt_index,
  output var logic mgmt_wr,
  output var logic mgmt_rd,
  output var plm_pkg::plm_word_t mgmt_wdata,
  output var logic sw_reset
);
  timeunit 1ns;
  timeprecision 1ns;
  import plm_pkg::*;
  // Idle request lines
  initial
  begin
    {mgmt_index, mgmt_wr, mgmt_rd, mgmt_wdata, sw_reset} = '0;
  end
  // One write; the logic-reset bit is ended by writing 0 again
  task automatic wr(input plm_index_t i, input plm_word_t d);
    @(posedge clk);
    mgmt_wr <= 1'b1;
    mgmt_index <= i;
    mgmt_wdata <= d;
    @(posedge clk);
    mgmt_wr <= 1'b0;
    #1;
  endtask
  // One read, answer taken the cycle after
  task automatic rd(input plm_index_t i, output logic a, output plm_word_t d);
    @(posedge clk);
    mgmt_rd <= 1'b1;
    mgmt_index <= i;
    @(posedge clk);
    mgmt_rd <= 1'b0;
    #1;
    a = mgmt_rd_ack;
    d = mgmt_rdata;
  endtask
  // Software reset pulse; energy status is cleared outside, change flag raised if energy was present
  task automatic swr();
    @(posedge clk);
    sw_reset <= 1'b1;
    @(posedge clk);
    sw_reset <= 1'b0;
    #1;
  endtask
endmodule
`default_nettype wire

/* File: dv/plm_sva.sv */
// Checker of the link mode register bank, port side and observed controls.
// Assumes binding onto plm_link_mode_regs, one clock.
`include "plm_consts.svh"
`default_nettype none
module plm_sva
  import plm_pkg::*;
(
  // Clock, reset and register port
  input wire logic clk,
  input wire logic rst,
  input wire logic sw_reset,
  input wire plm_pkg::plm_index_t mgmt_index,
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire plm_pkg::plm_word_t mgmt_wdata,
  input wire logic mgmt_rd_ack,
  input wire plm_pkg::plm_word_t mgmt_rdata,
  // Observed controls
  input wire logic idle_err_count_read,
  input wire logic [`PLM_IERR_WIDTH-1:0] idle_err_count,
  input wire logic link_fail,
  input wire logic core_logic_reset,
  input wire logic power_opt_enable,
  input wire logic [2:0] downshift_attempts,
  input wire logic edpd_active,
  input wire logic energy_change_irq_flag_set,
  input wire logic auto_pair01_crossed,
  input wire logic pair01_crossed
);
  timeunit 1ns;
  timeprecision 1ns;
  // ====
  // Helpers
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [2:0] att [4] = '{3'h7, 3'h5, 3'h4, 3'h3};
  logic w10, w11, clr;
  assign w10 = mgmt_wr && mgmt_index == 5'h10;
  assign w11 = mgmt_wr && mgmt_index == 5'h11;
  assign clr = idle_err_count_read || sw_reset || core_logic_reset;
  // ====
  // Assertions
  a_attempt_code: assert property (w10 |=> downshift_attempts == att[$past(mgmt_wdata[9:8])])
    else $error("attempt count wrong");
  a_power_opt: assert property (w10 |=> power_opt_enable == !$past(mgmt_wdata[2]))
    else $error("power optimisation wrong");
  a_logic_rst: assert property (w10 |=> core_logic_reset == $past(mgmt_wdata[0]))
    else $error("logic reset bit wrong");
  a_fail_blocked: assert property (core_logic_reset |=> !link_fail)
    else $error("link failed in logic reset");
  a_count_clear: assert property (clr |=> idle_err_count == 8'h00)
    else $error("counter not cleared");
  a_count_sat: assert property (idle_err_count == 8'hff && !clr |=> idle_err_count == 8'hff)
    else $error("counter left saturation");
  a_edpd_off: assert property (w11 && !mgmt_wdata[13] |=> !edpd_active)
    else $error("power-down while disabled");
  a_auto_xover: assert property (w11 && !mgmt_wdata[5] |=> pair01_crossed == auto_pair01_crossed)
    else $error("crossover not automatic");
  a_rsv_zero: assert property (mgmt_rd && mgmt_index == 5'h10 |=> mgmt_rd_ack ##0 (mgmt_rdata & 16'hfcc2) == 16'h0000)
    else $error("reserved bits not zero");
  // Main scenarios seen
  cover property (energy_change_irq_flag_set);
  cover property (idle_err_count == 8'hff);
  cover property (link_fail);
endmodule
bind plm_link_mode_regs plm_sva chk (.*);
`default_nettype wire

/* File: dv/tb.sv */
// Self-checking bench of the link mode register bank.
// Assumes the checker binds itself and the model drives the port.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import plm_pkg::*;
  // ====
  // Signals
  logic clk, rst, sw_reset, mgmt_wr, mgmt_rd, mgmt_rd_ack, idle_err_pulse, idle_err_count_read;
  logic link_fail, line_energy_raw, energy_change_irq_flag_set, edpd_active, edpd_send_nlp;
  logic energy_detect_short_mode, core_logic_reset, power_opt_enable, ten_meg_test_mode;
  logic semi_xover_enable, downshift_enable, adv_next_page, next_page_enable, next_page_advertise;
  logic auto_pair01_crossed, auto_pair23_crossed, manual_pair01_crossed, manual_pair23_crossed;
  logic pair01_crossed, pair23_crossed, a;
  plm_index_t mgmt_index;
  plm_word_t mgmt_wdata, mgmt_rdata, d;
  logic [7:0] idle_err_count;
  logic [3:0] idle_err_rate_over;
  logic [2:0] downshift_attempts;
  logic [2:0] att [4] = '{3'h7, 3'h5, 3'h4, 3'h3};
  int error_cnt, total_checks;
  plm_link_mode_regs uut (.*);
  plm_mgmt_model pm (.*);
  // Clock
  always #5 clk = ~clk;
  // ====
  // Helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulses(input int n);
    @(posedge clk) idle_err_pulse <= 1'b1;
    repeat (n) @(posedge clk);
    idle_err_pulse <= 1'b0;
    #1;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ====
  // Scenarios
  task automatic t_reset();
    pm.rd(5'h10, a, d);
    chk(d, 16'h0020);
    pm.rd(5'h11, a, d);
    chk(d, 16'h0042);
    chk(downshift_attempts, 3'h7);
    chk(power_opt_enable, 1'b1);
    $display("reset values done");
  endtask
  task automatic t_link_ctrl();
    for (int c = 0; c < 4; c++)
    begin
      pm.wr(5'h10, {6'h00, 2'(c), 8'h00});
      chk(downshift_attempts, att[c]);
    end
    pm.wr(5'h10, 16'hffff);
    chk(core_logic_reset, 1'b1);
    chk(power_opt_enable, 1'b0);
    pm.rd(5'h10, a, d);
    chk(d, 16'h033d);
    pm.rd(5'h12, a, d);
    chk(a, 1'b1);
    chk(d, 16'h0000);
    pm.wr(5'h10, 16'h0000);
    chk(core_logic_reset, 1'b0);
    $display("link control done");
  endtask
  task automatic t_link_break();
    for (int k = 0; k < 4; k++)
    begin
      pm.wr(5'h10, 16'(16'h0008 | (k << 4)));
      @(posedge clk) idle_err_rate_over <= 4'h1 << k;
      cyc(2);
      chk(link_fail, 1'b1);
      @(posedge clk) idle_err_rate_over <= ~(4'h1 << k);
      cyc(2);
      chk(link_fail, 1'b0);
    end
    @(posedge clk) idle_err_rate_over <= 4'hf;
    pm.wr(5'h10, 16'h0009);
    cyc(2);
    chk(link_fail, 1'b0);
    pm.wr(5'h10, 16'h0000);
    cyc(2);
    chk(link_fail, 1'b0);
    $display("link break done");
  endtask
  task automatic t_mode();
    @(posedge clk)
    {manual_pair01_crossed, auto_pair23_crossed} <= 2'h3;
    pm.wr(5'h11, 16'hffff);
    pm.rd(5'h11, a, d);
    chk(d, 16'hf0f3);
    chk({energy_detect_short_mode, ten_meg_test_mode, edpd_send_nlp}, 3'h7);
    chk({downshift_enable, semi_xover_enable, edpd_active}, 3'h6);
    chk({pair01_crossed, pair23_crossed, next_page_advertise}, 3'h4);
    pm.wr(5'h11, 16'h0040);
    chk({next_page_enable, next_page_advertise, edpd_send_nlp}, 3'h6);
    chk({pair01_crossed, pair23_crossed}, 2'h1);
    $display("mode control done");
  endtask
  task automatic t_energy();
    pm.wr(5'h11, 16'h2000);
    @(posedge clk) line_energy_raw <= 1'b0;
    cyc(5);
    chk(edpd_active, 1'b1);
    pm.rd(5'h11, a, d);
    chk(d, 16'h2000);
    @(posedge clk) line_energy_raw <= 1'b1;
    cyc(5);
    chk(edpd_active, 1'b0);
    pm.swr();
    chk({energy_change_irq_flag_set, edpd_active}, 2'h3);
    pm.wr(5'h11, 16'h0040);
    $display("energy detect done");
  endtask
  task automatic t_counter();
    pulses(3);
    chk(idle_err_count, 8'h03);
    @(posedge clk) idle_err_count_read <= 1'b1;
    @(posedge clk) idle_err_count_read <= 1'b0;
    cyc(0);
    chk(idle_err_count, 8'h00);
    pulses(260);
    chk(idle_err_count, 8'hff);
    pm.swr();
    chk(idle_err_count, 8'h00);
    pulses(2);
    pm.wr(5'h10, 16'h0001);
    cyc(1);
    chk(idle_err_count, 8'h00);
    pm.wr(5'h10, 16'h0000);
    $display("idle counter done");
  endtask
  // ====
  // Main sequence and watchdog
  initial
  begin
    {clk, rst, idle_err_pulse, idle_err_count_read, adv_next_page} = 5'h08;
    {auto_pair01_crossed, auto_pair23_crossed, manual_pair01_crossed, manual_pair23_crossed} = 4'h0;
    idle_err_rate_over = 4'h0;
    line_energy_raw = 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    cyc(4);
    t_reset();
    t_link_ctrl();
    t_link_break();
    t_mode();
    t_energy();
    t_counter();
    finish_test();
  end
  initial
  begin
    #50us;
    error_cnt++;
    finish_test();
  end
endmodule
`default_nettype wire

/* File: rtl/plm_consts.svh */
// Constants of the link and 10/100 mode control register pair.
// Assumes inclusion by bare name from the package and the register bank.
`ifndef PLM_CONSTS_SVH
`define PLM_CONSTS_SVH
// ==========================================
// Register indices on the management port
`define PLM_IDX_LINK_CTRL 5'h10
`define PLM_IDX_TH_MODE 5'h11
// ==========================================
// Link control field positions
`define PLM_LC_SPD_ATT_HI 9
`define PLM_LC_SPD_ATT_LO 8
`define PLM_LC_BRK_TH_HI 5
`define PLM_LC_BRK_TH_LO 4
`define PLM_LC_BRK_EN 3
`define PLM_LC_PWR_DIS 2
`define PLM_LC_LOGIC_RST 0
// ==========================================
// 10/100 mode control/status field positions
`define PLM_TM_ED_SHORT 15
`define PLM_TM_FAST_TEN 14
`define PLM_TM_EDPD_EN 13
`define PLM_TM_EDPD_NLP 12
`define PLM_TM_SPD_OPT_EN 7
`define PLM_TM_NP_EN 6
`define PLM_TM_XOVER_DIS 5
`define PLM_TM_AUTO_NP_DIS 4
`define PLM_TM_ENERGY 1
`define PLM_TM_SEMI_XOVER 0
// ==========================================
// Writable masks and reset values
`define PLM_LC_WMASK 16'h033d
`define PLM_TM_WMASK 16'hf0f1
`define PLM_LC_RESET 16'h0020
`define PLM_TM_RESET 16'h0040
`define PLM_ENERGY_HW_RESET 1'b1
// ==========================================
// Idle error counter
`define PLM_IERR_WIDTH 8
`endif

/* File: rtl/plm_idle_err_cnt.sv */
// Saturating idle error counter with synchronous clear.
// Assumes its error pulses come from logic on the same clock.
`include "plm_consts.svh"
`default_nettype none
module plm_idle_err_cnt
  import plm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link to the register bank
  plm_ierr_if.cnt ierr
);
  import plm_pkg::*;
  localparam logic [`PLM_IERR_WIDTH-1:0] CNT_MAX = '1;
  plm_ierr_t st_q;
  plm_ierr_t st_d;
  // ==========================================
  // Next count: clear first, then saturating increment
  always_comb
  begin
    st_d = st_q;
    if (ierr.clear)
    begin
      st_d.count = '0;
    end
    else if (ierr.err_pulse && st_q.count != CNT_MAX)
    begin
      st_d.count = st_q.count + 1'b1;
    end
  end
  // ==========================================
  // State register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end
  // Outputs
  assign ierr.count = st_q.count;
  assign ierr.saturated = (st_q.count == CNT_MAX);
endmodule
`default_nettype wire

/* File: rtl/plm_ierr_if.sv */
// Carrier between the register bank and its idle error counter.
// Assumes both ends run on the same clock.
`include "plm_consts.svh"
`default_nettype none
interface plm_ierr_if;
  // Error event and clear request from the bank
  logic err_pulse;
  logic clear;
  // Count back to the bank
  logic [`PLM_IERR_WIDTH-1:0] count;
  logic saturated;
  modport bank (output err_pulse, output clear, input count, input saturated);
  modport cnt (input err_pulse, input clear, output count, output saturated);
endinterface
`default_nettype wire

/* File: rtl/plm_link_mode_regs.sv */
// Link control and 10/100 mode control/status registers of the transceiver.
// Assumes a management engine on clk drives the register port, and that
// hardware reset arrives on rst and software reset as a one-cycle pulse.
`include "plm_consts.svh"
`default_nettype none
module plm_link_mode_regs
  import plm_pkg::*;
(
  // Clock and hardware reset
  input wire logic clk,
  input wire logic rst,
  // Software reset pulse from the basic control register
  input wire logic sw_reset,
  // Management register port
  input wire plm_pkg::plm_index_t mgmt_index,
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire plm_pkg::plm_word_t mgmt_wdata,
  output logic mgmt_rd_ack,
  output plm_pkg::plm_word_t mgmt_rdata,
  // Idle error counter access
  input wire logic idle_err_pulse,
  input wire logic idle_err_count_read,
  output logic [`PLM_IERR_WIDTH-1:0] idle_err_count,
  // Idle error rate monitor, one flag per threshold code
  input wire logic [3:0] idle_err_rate_over,
  output logic link_fail,
  // Energy detector on the line side
  input wire logic line_energy_raw,
  output logic energy_change_irq_flag_set,
  output logic edpd_active,
  output logic edpd_send_nlp,
  output logic energy_detect_short_mode,
  // Core control
  output logic core_logic_reset,
  output logic power_opt_enable,
  output logic ten_meg_test_mode,
  output logic semi_xover_enable,
  // Speed downshift
  output logic downshift_enable,
  output logic [2:0] downshift_attempts,
  // Next pages
  input wire logic adv_next_page,
  output logic next_page_enable,
  output logic next_page_advertise,
  // Crossover
  input wire logic auto_pair01_crossed,
  input wire logic auto_pair23_crossed,
  input wire logic manual_pair01_crossed,
  input wire logic manual_pair23_crossed,
  output logic pair01_crossed,
  output logic pair23_crossed
);
  import plm_pkg::*;

  // ==========================================
  // Helpers

  // Attempts before the advertised speed is lowered
  function automatic logic [2:0] attempts_of(input logic [1:0] code);
    logic [2:0] n;
    n = 3'h7;
    unique case (code)
      2'h0: n = 3'h7;
      2'h1: n = 3'h5;
      2'h2: n = 3'h4;
      2'h3: n = 3'h3;
    endcase
    return n;
  endfunction

  // Register image gated by its writable mask
  function automatic plm_word_t masked_write(input plm_word_t old_v, input plm_word_t new_v,
                                             input plm_word_t mask);
    return (old_v & ~mask) | (new_v & mask);
  endfunction

  plm_bank_t st_q;
  plm_bank_t st_d;
  plm_ierr_if ierr ();

  logic wr_link;
  logic wr_mode;
  logic rd_link;
  logic rd_mode;
  logic [1:0] brk_code;

  // ==========================================
  // Address decode
  assign wr_link = mgmt_wr && (mgmt_index == `PLM_IDX_LINK_CTRL);
  assign wr_mode = mgmt_wr && (mgmt_index == `PLM_IDX_TH_MODE);
  assign rd_link = mgmt_rd && (mgmt_index == `PLM_IDX_LINK_CTRL);
  assign rd_mode = mgmt_rd && (mgmt_index == `PLM_IDX_TH_MODE);
  assign brk_code = st_q.link_ctrl[`PLM_LC_BRK_TH_HI:`PLM_LC_BRK_TH_LO];

  // ==========================================
  // Idle error counter
  // Clears on read, software reset and logic reset; hardware reset is rst
  assign ierr.err_pulse = idle_err_pulse;
  assign ierr.clear = idle_err_count_read || sw_reset || st_q.core_logic_reset;

  plm_idle_err_cnt u_ierr (
    .clk(clk),
    .rst(rst),
    .ierr(ierr)
  );

  // ==========================================
  // Next state of the bank
  always_comb
  begin
    st_d = st_q;
    st_d.rd_ack = 1'b0;
    st_d.energy_change_set = 1'b0;

    // Energy input passes two flops before use
    st_d.energy_meta = line_energy_raw;
    st_d.energy_sync = st_q.energy_meta;

    // Software writes; reserved bits never store
    if (wr_link)
    begin
      st_d.link_ctrl = masked_write(st_q.link_ctrl, mgmt_wdata, `PLM_LC_WMASK);
    end
    if (wr_mode)
    begin
      st_d.th_mode = masked_write(st_q.th_mode, mgmt_wdata, `PLM_TM_WMASK);
    end

    // Logic reset follows the stored bit; a write of 0 or hardware reset clears it
    st_d.core_logic_reset = st_d.link_ctrl[`PLM_LC_LOGIC_RST];

    // Energy-present status follows the line, cleared by software reset
    if (sw_reset)
    begin
      st_d.energy_present = 1'b0;
      st_d.energy_change_set = st_q.energy_present;
    end
    else
    begin
      st_d.energy_present = st_q.energy_sync;
      st_d.energy_change_set = st_q.energy_sync != st_q.energy_present;
    end

    // Link break needs the enable and the selected threshold exceeded
    st_d.link_fail = st_q.link_ctrl[`PLM_LC_BRK_EN] && idle_err_rate_over[brk_code]
                     && !st_q.core_logic_reset;

    // Read data, reserved bits read as zero
    if (rd_link)
    begin
      st_d.rd_data = st_q.link_ctrl & `PLM_LC_WMASK;
      st_d.rd_ack = 1'b1;
    end
    else if (rd_mode)
    begin
      st_d.rd_data = (st_q.th_mode & `PLM_TM_WMASK)
                     | (16'(st_q.energy_present) << `PLM_TM_ENERGY);
      st_d.rd_ack = 1'b1;
    end
    else if (mgmt_rd)
    begin
      st_d.rd_data = 16'h0000;
      st_d.rd_ack = 1'b1;
    end
  end

  // ==========================================
  // State register; hardware reset loads documented defaults
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= '0;
      st_q.link_ctrl <= `PLM_LC_RESET;
      st_q.th_mode <= `PLM_TM_RESET;
      st_q.energy_present <= `PLM_ENERGY_HW_RESET;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ==========================================
  // Management answers
  assign mgmt_rd_ack = st_q.rd_ack;
  assign mgmt_rdata = st_q.rd_data;
  assign idle_err_count = ierr.count;

  // ==========================================
  // Energy and power-down controls
  assign energy_change_irq_flag_set = st_q.energy_change_set;
  assign energy_detect_short_mode = st_q.th_mode[`PLM_TM_ED_SHORT];
  assign edpd_active = st_q.th_mode[`PLM_TM_EDPD_EN] && !st_q.energy_present;
  assign edpd_send_nlp = st_q.th_mode[`PLM_TM_EDPD_NLP];

  // ==========================================
  // Core controls
  assign core_logic_reset = st_q.core_logic_reset;
  assign link_fail = st_q.link_fail;
  assign power_opt_enable = !st_q.link_ctrl[`PLM_LC_PWR_DIS];
  assign ten_meg_test_mode = st_q.th_mode[`PLM_TM_FAST_TEN];
  assign semi_xover_enable = st_q.th_mode[`PLM_TM_SEMI_XOVER];

  // ==========================================
  // Speed downshift
  assign downshift_enable = st_q.th_mode[`PLM_TM_SPD_OPT_EN];
  assign downshift_attempts = attempts_of(st_q.link_ctrl[`PLM_LC_SPD_ATT_HI:`PLM_LC_SPD_ATT_LO]);

  // ==========================================
  // Next pages
  assign next_page_enable = st_q.th_mode[`PLM_TM_NP_EN];
  assign next_page_advertise = st_q.th_mode[`PLM_TM_AUTO_NP_DIS] ? adv_next_page
                                                                  : st_q.th_mode[`PLM_TM_NP_EN];

  // ==========================================
  // Crossover: manual selects only count while automatic is disabled
  assign pair01_crossed = st_q.th_mode[`PLM_TM_XOVER_DIS] ? manual_pair01_crossed
                                                           : auto_pair01_crossed;
  assign pair23_crossed = st_q.th_mode[`PLM_TM_XOVER_DIS] ? manual_pair23_crossed
                                                           : auto_pair23_crossed;
endmodule
`default_nettype wire

/* File: rtl/plm_pkg.sv */
// Types shared by the link mode control register bank.
// Assumes the constants header sits beside it on the include path.
`default_nettype none
package plm_pkg;
`include "plm_consts.svh"
  // ==========================================
  // Register images
  typedef logic [15:0] plm_word_t;
  typedef logic [4:0] plm_index_t;
  // ==========================================
  // State of the register bank
  typedef struct packed {
    plm_word_t link_ctrl;
    plm_word_t th_mode;
    logic energy_meta;
    logic energy_sync;
    logic energy_present;
    logic sw_reset_seen;
    logic core_logic_reset;
    plm_word_t rd_data;
    logic rd_ack;
    logic energy_change_set;
    logic link_fail;
  } plm_bank_t;
  // ==========================================
  // State of the idle error counter
  typedef struct packed {
    logic [`PLM_IERR_WIDTH-1:0] count;
  } plm_ierr_t;
endpackage
`default_nettype wire
